// ==== logic/sbn_pkg.sv ====
// constants, types and arithmetic for the subtract-borrow and nibble-exchange datapath
package sbn_pkg;
  // ==========================================================
  // register offsets on the plain register port
  localparam logic [3:0] OFF_INSN = 4'h0;
  localparam logic [3:0] OFF_ACC = 4'h1;
  localparam logic [3:0] OFF_STATUS = 4'h2;
  localparam logic [3:0] OFF_BANK = 4'h3;
  localparam logic [3:0] OFF_MADDR = 4'h4;
  localparam logic [3:0] OFF_MDATA = 4'h5;
  localparam logic [3:0] OFF_STATE = 4'h6;

  // ==========================================================
  // status bit positions
  localparam int FLG_C = 0;
  localparam int FLG_DC = 1;
  localparam int FLG_Z = 2;
  localparam int FLG_OV = 3;
  localparam int FLG_N = 4;
  localparam int FLG_ILL = 5;
  localparam logic [5:0] STATUS_RST = 6'h00;

  // ==========================================================
  // instruction word layout
  localparam int INSN_OP_HI = 15;
  localparam int INSN_OP_LO = 10;
  localparam int INSN_D = 9;
  localparam int INSN_A = 8;
  localparam logic [5:0] OPC_SUB_BORROW = 6'h16;
  localparam logic [5:0] OPC_NIBBLE_EXCH = 6'h0e;
  localparam logic [7:0] ACCESS_SPLIT = 8'h80;

  // ==========================================================
  // reset values
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [15:0] INSN_RST = 16'h0000;

  typedef enum logic [2:0] {
    SBN_IDLE,
    SBN_DECODE,
    SBN_READ,
    SBN_PROCESS,
    SBN_WRITE
  } sbn_state_e;

  typedef enum logic [1:0] {
    SBN_OP_NONE,
    SBN_OP_SUB,
    SBN_OP_SWAP
  } sbn_op_e;

  // returns {n, ov, z, dc, c, result}
  function automatic logic [12:0] sbn_sub(input logic [7:0] f, input logic [7:0] w,
                                          input logic c);
    logic [8:0] full;
    logic [4:0] low;
    logic [7:0] r;
    full = {1'b0, f} - {1'b0, w} - {8'h00, ~c};
    low = {1'b0, f[3:0]} - {1'b0, w[3:0]} - {4'h0, ~c};
    r = full[7:0];
    // carry and digit carry are active-high "no borrow"
    sbn_sub = {r[7], (f[7] ^ w[7]) & (f[7] ^ r[7]), r == 8'h00, ~low[4], ~full[8], r};
  endfunction
endpackage

// ==== logic/sbn_core.sv ====
// four-phase execution datapath for subtract-with-borrow and nibble exchange
`timescale 1ns/10ps
`default_nettype none

// Contract
// - subtract computes f minus accumulator minus inverted carry; updates N, OV, C, DC, Z.
// - destination bit clear writes accumulator; set writes result back to file register.
// - access bit clear takes address from the fast access bank, ignoring bank pointer.
// - access bit set places the file register in the bank named by bank pointer.
module sbn_core
  import sbn_pkg::*;
#(
  parameter int BANK_W = 4
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic we_i,
  input wire logic re_i,
  output logic [15:0] rdata_o,
  output logic busy_o
);
  localparam int AW = BANK_W + 8;
  localparam int DEPTH = 1 << AW;

  // ==========================================================
  // reset release
  logic [1:0] rst_sync_q;
  logic rst_n;

  // not gated by ce_i so reset still releases while the core is frozen
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // ==========================================================
  // state
  sbn_state_e state_q, state_d;
  sbn_op_e op_q, op_d;
  logic [15:0] insn_q, insn_d;
  logic [7:0] acc_q, acc_d;
  logic [5:0] stat_q, stat_d;
  logic [BANK_W-1:0] bank_q, bank_d;
  logic [AW-1:0] maddr_q, maddr_d;
  logic [AW-1:0] faddr_q, faddr_d;
  logic [7:0] opnd_q, opnd_d;
  logic [7:0] res_q, res_d;
  logic [4:0] flg_q, flg_d;
  logic [15:0] rdata_q, rdata_d;
  logic busy_q, busy_d;
  logic [7:0] mem [DEPTH];
  logic mem_we;
  logic [AW-1:0] mem_wa;
  logic [7:0] mem_wd;
  logic [12:0] sub_v;
  logic dest_file;

  assign dest_file = insn_q[INSN_D];
  assign sub_v = sbn_sub(opnd_q, acc_q, stat_q[FLG_C]);

  // ==========================================================
  // next-state logic
  always_comb begin
    state_d = state_q;
    op_d = op_q;
    insn_d = insn_q;
    acc_d = acc_q;
    stat_d = stat_q;
    bank_d = bank_q;
    maddr_d = maddr_q;
    faddr_d = faddr_q;
    opnd_d = opnd_q;
    res_d = res_q;
    flg_d = flg_q;
    rdata_d = 16'h0000;
    mem_we = 1'b0;
    mem_wa = maddr_q;
    mem_wd = wdata_i[7:0];
    // register port; all writes, status included, are refused while busy
    if (re_i) begin
      case (addr_i)
        OFF_INSN: rdata_d = insn_q;
        OFF_ACC: rdata_d = {8'h00, acc_q};
        OFF_STATUS: rdata_d = {10'h000, stat_q};
        OFF_BANK: rdata_d = {{(16 - BANK_W){1'b0}}, bank_q};
        OFF_MADDR: rdata_d = {{(16 - AW){1'b0}}, maddr_q};
        OFF_MDATA: rdata_d = {8'h00, mem[maddr_q]};
        OFF_STATE: rdata_d = {12'h000, state_q == SBN_IDLE ? 1'b0 : 1'b1, state_q};
        default: rdata_d = 16'h0000;
      endcase
    end
    if (we_i && state_q == SBN_IDLE) begin
      case (addr_i)
        OFF_INSN: begin
          insn_d = wdata_i;
          state_d = SBN_DECODE;
        end
        OFF_ACC: acc_d = wdata_i[7:0];
        OFF_STATUS: stat_d = wdata_i[5:0];
        OFF_BANK: bank_d = wdata_i[BANK_W-1:0];
        OFF_MADDR: maddr_d = wdata_i[AW-1:0];
        OFF_MDATA: mem_we = 1'b1;
        default: ;
      endcase
    end
    case (state_q)
      SBN_IDLE: ;
      SBN_DECODE: begin
        if (insn_q[INSN_A]) begin
          faddr_d = {bank_q, insn_q[7:0]};
        end else if (insn_q[7:0] < ACCESS_SPLIT) begin
          faddr_d = {{BANK_W{1'b0}}, insn_q[7:0]};
        end else begin
          faddr_d = {{BANK_W{1'b1}}, insn_q[7:0]};
        end
        if (insn_q[INSN_OP_HI:INSN_OP_LO] == OPC_SUB_BORROW) begin
          op_d = SBN_OP_SUB;
          state_d = SBN_READ;
        end else if (insn_q[INSN_OP_HI:INSN_OP_LO] == OPC_NIBBLE_EXCH) begin
          op_d = SBN_OP_SWAP;
          state_d = SBN_READ;
        end else begin
          // unknown opcode aborts without touching data; sticky until software clears
          op_d = SBN_OP_NONE;
          stat_d[FLG_ILL] = 1'b1;
          state_d = SBN_IDLE;
        end
      end
      SBN_READ: begin
        opnd_d = mem[faddr_q];
        state_d = SBN_PROCESS;
      end
      SBN_PROCESS: begin
        if (op_q == SBN_OP_SUB) begin
          res_d = sub_v[7:0];
          flg_d = sub_v[12:8];
        end else begin
          res_d = {opnd_q[3:0], opnd_q[7:4]};
        end
        state_d = SBN_WRITE;
      end
      SBN_WRITE: begin
        if (dest_file) begin
          mem_we = 1'b1;
          mem_wa = faddr_q;
          mem_wd = res_q;
        end else begin
          acc_d = res_q;
        end
        if (op_q == SBN_OP_SUB) begin
          stat_d[FLG_N] = flg_q[4];
          stat_d[FLG_OV] = flg_q[3];
          stat_d[FLG_Z] = flg_q[2];
          stat_d[FLG_DC] = flg_q[1];
          stat_d[FLG_C] = flg_q[0];
        end
        state_d = SBN_IDLE;
      end
      default: state_d = SBN_IDLE;
    endcase
    busy_d = state_d != SBN_IDLE;
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= SBN_IDLE;
      op_q <= SBN_OP_NONE;
      insn_q <= INSN_RST;
      acc_q <= ACC_RST;
      stat_q <= STATUS_RST;
      bank_q <= '0;
      maddr_q <= '0;
      faddr_q <= '0;
      opnd_q <= 8'h00;
      res_q <= 8'h00;
      flg_q <= 5'h00;
      rdata_q <= 16'h0000;
      busy_q <= 1'b0;
    end else if (ce_i) begin
      state_q <= state_d;
      op_q <= op_d;
      insn_q <= insn_d;
      acc_q <= acc_d;
      stat_q <= stat_d;
      bank_q <= bank_d;
      maddr_q <= maddr_d;
      faddr_q <= faddr_d;
      opnd_q <= opnd_d;
      res_q <= res_d;
      flg_q <= flg_d;
      rdata_q <= rdata_d;
      busy_q <= busy_d;
    end
  end

  // file memory is not reset, software must initialise it
  always_ff @(posedge clk_i) begin
    if (ce_i && rst_n && mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  assign rdata_o = rdata_q;
  assign busy_o = busy_q;

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  AST_SUB_RESULT: assert property (
    (state_q == SBN_PROCESS && op_q == SBN_OP_SUB && ce_i)
    |=> res_q == 8'(($past(opnd_q) - $past(acc_q)) - {7'h00, ~$past(stat_q[FLG_C])}))
    else $error("subtract result wrong");

  AST_SUB_FLAGS: assert property (
    (state_q == SBN_WRITE && op_q == SBN_OP_SUB && ce_i)
    |=> stat_q[FLG_N] == $past(res_q[7]) && stat_q[FLG_Z] == ($past(res_q) == 8'h00))
    else $error("subtract flags wrong");

  AST_DEST_ACC: assert property (
    (state_q == SBN_WRITE && !dest_file && ce_i) |=> acc_q == $past(res_q))
    else $error("accumulator not written");

  AST_DEST_FILE: assert property (
    (state_q == SBN_WRITE && dest_file && ce_i)
    |-> mem_we && mem_wa == faddr_q ##1 $stable(acc_q))
    else $error("file register not written");

  AST_ACCESS_BANK: assert property (
    (state_q == SBN_DECODE && !insn_q[INSN_A] && ce_i)
    |=> faddr_q[AW-1:8] == (faddr_q[7] ? {BANK_W{1'b1}} : {BANK_W{1'b0}}))
    else $error("access bank address wrong");

  AST_BANK_PTR: assert property (
    (state_q == SBN_DECODE && insn_q[INSN_A] && ce_i) |=> faddr_q[AW-1:8] == $past(bank_q))
    else $error("bank pointer not used");

  AST_FOUR_PHASE: assert property (
    (state_q == SBN_READ && ce_i) ##1 ce_i [*2]
    |-> state_q == SBN_WRITE ##1 state_q == SBN_IDLE)
    else $error("phase sequence broken");

  // flag checks are worked out from the operands, not from the flag logic
  // carry and digit carry read as no-borrow
  AST_SUB_CARRY: assert property (
    (state_q == SBN_PROCESS && op_q == SBN_OP_SUB && ce_i)
    |=> flg_q[0] == ({1'b0, $past(opnd_q)}
                     >= {1'b0, $past(acc_q)} + {8'h00, ~$past(stat_q[FLG_C])}))
    else $error("subtract carry wrong");

  AST_SUB_DIGIT: assert property (
    (state_q == SBN_PROCESS && op_q == SBN_OP_SUB && ce_i)
    |=> flg_q[1] == ({1'b0, $past(opnd_q[3:0])}
                     >= {1'b0, $past(acc_q[3:0])} + {4'h0, ~$past(stat_q[FLG_C])}))
    else $error("subtract digit carry wrong");

  AST_SUB_OVERFLOW: assert property (
    (state_q == SBN_PROCESS && op_q == SBN_OP_SUB && ce_i)
    |=> flg_q[3] == ($past(opnd_q[7]) != $past(acc_q[7])
                     && $past(opnd_q[7]) != res_q[7]))
    else $error("subtract overflow wrong");

  AST_SWAP_FLAGS: assert property (
    (state_q == SBN_WRITE && op_q == SBN_OP_SWAP && ce_i) |=> $stable(stat_q))
    else $error("exchange touched the flags");

  AST_ACC_DEST_NO_FILE: assert property (
    (state_q == SBN_WRITE && !dest_file && ce_i) |-> !mem_we)
    else $error("file register written for accumulator destination");

  AST_ACC_HELD: assert property (
    ((state_q == SBN_DECODE || state_q == SBN_READ || state_q == SBN_PROCESS) && ce_i)
    |=> $stable(acc_q))
    else $error("accumulator changed before write phase");

  // a stall must not skip or repeat a phase
  AST_CE_FREEZE: assert property (
    !ce_i |=> $stable(state_q) && $stable(acc_q) && $stable(stat_q) && $stable(faddr_q))
    else $error("state moved while clock enable low");

  // ==========================================================
  // cover points
  COV_SUB_ACC: cover property (state_q == SBN_WRITE && op_q == SBN_OP_SUB && !dest_file);
  COV_SWAP_FILE: cover property (state_q == SBN_WRITE && op_q == SBN_OP_SWAP && dest_file);
  COV_ILLEGAL: cover property (state_q == SBN_DECODE && op_d == SBN_OP_NONE);
  COV_CE_FREEZE: cover property (state_q == SBN_PROCESS && !ce_i);
  COV_BANK_PTR: cover property (state_q == SBN_DECODE && insn_q[INSN_A]);
endmodule

`default_nettype wire

// ==== dv/tb.sv ====
// self-checking bench for the subtract-borrow and nibble-exchange datapath
`timescale 1ns/10ps
`default_nettype none
module tb;
  import sbn_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic ce = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic we = 1'b0;
  logic re = 1'b0;
  logic [15:0] rdata;
  logic busy;
  logic [31:0] seed = 32'he46f;
  int bad_count = 0;
  int n_checks = 0;
  int cyc = 0;

  sbn_core #(.BANK_W(4)) i_sbn_core (.clk_i(clk), .rst_b_i(rst_b), .ce_i(ce), .addr_i(addr),
    .wdata_i(wdata), .we_i(we), .re_i(re), .rdata_o(rdata), .busy_o(busy));

  always #5 clk = ~clk;

  // ==========================================================
  // reporting
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // a dozen instructions need a few hundred cycles; far above that means a hang
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      $display("[ERR] %0t timeout", $time);
      bad_count++;
      give_verdict();
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // ==========================================================
  // register port master
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    we <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    we <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk);
    re <= 1'b1;
    addr <= a;
    @(posedge clk);
    re <= 1'b0;
    #1;
    chk(rdata, exp);
    // read data stand for one cycle only, then fall back to zero
    @(posedge clk);
    #1;
    chk(rdata, 16'h0000);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    logic [7:0] f, w, m, r;
    logic [3:0] bk;
    logic [5:0] op, st;
    logic [11:0] fa;
    logic c, d, a, lg;
    int fl, lo, k;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    rd(OFF_ACC, 16'h0000);
    rd(OFF_STATUS, 16'h0000);
    for (int i = 0; i < 12; i++) begin
      seed = xs(seed);
      f = seed[7:0];
      w = seed[15:8];
      m = seed[23:16];
      bk = seed[27:24];
      c = seed[28];
      if (i == 0) begin
        m = 8'h19;
        w = 8'h0d;
        c = 1'b1;
      end
      d = i[0];
      a = i[1];
      f[7] = i[2];
      op = (i % 3 == 2) ? OPC_NIBBLE_EXCH : OPC_SUB_BORROW;
      if (i == 11) op = 6'h3f;
      // access bank splits at 0x80: low half from bank 0, high half from the top bank
      fa = a ? {bk, f} : {(f[7] ? 4'hf : 4'h0), f};
      fl = int'(m) - int'(w) - 1 + int'(c);
      lo = int'(m[3:0]) - int'(w[3:0]) - 1 + int'(c);
      lg = 1'b1;
      if (op == OPC_SUB_BORROW) begin
        r = fl[7:0];
        st = {1'b0, r[7], (m[7] ^ w[7]) & (m[7] ^ r[7]), r == 8'h00, lo >= 0, fl >= 0};
      end else if (op == OPC_NIBBLE_EXCH) begin
        r = {m[3:0], m[7:4]};
        st = {5'h00, c};
      end else begin
        r = m;
        st = {1'b1, 4'h0, c};
        lg = 1'b0;
      end
      wr(OFF_BANK, {12'h000, bk});
      wr(OFF_MADDR, {4'h0, fa});
      wr(OFF_MDATA, {8'h00, m});
      wr(OFF_ACC, {8'h00, w});
      wr(OFF_STATUS, {15'h0000, c});
      wr(OFF_INSN, {op, d, a, f});
      #1;
      k = (busy === 1'b1) ? 1 : 0;
      // one accumulator write lands mid-instruction and must be dropped;
      // the phase is read back in the read phase, and test 5 stalls for three cycles
      for (int t = 0; t < 12 && !(k > 0 && busy === 1'b0); t++) begin
        @(posedge clk);
        we <= lg && t == 1;
        re <= lg && t == 0;
        ce <= !(i == 5 && t >= 1 && t < 4);
        addr <= (t == 0) ? OFF_STATE : OFF_ACC;
        wdata <= 16'h00a5;
        #1;
        if (busy === 1'b1) k++;
        if (lg && t == 1) chk(rdata, 16'h000a);
      end
      chk(16'(k), lg ? ((i == 5) ? 16'h0007 : 16'h0004) : 16'h0001);
      rd(OFF_ACC, {8'h00, (lg && !d) ? r : w});
      rd(OFF_STATUS, {10'h000, st});
      rd(OFF_MDATA, {8'h00, (lg && d) ? r : m});
      rd(OFF_BANK, {12'h000, bk});
      rd(OFF_INSN, {op, d, a, f});
      $display("test %0d done", i);
    end
    // reset in mid-instruction must leave the core idle and cleared
    wr(OFF_ACC, 16'h0033);
    wr(OFF_INSN, {OPC_SUB_BORROW, 2'b00, 8'h10});
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk({15'h0000, busy}, 16'h0000);
    rd(OFF_ACC, 16'h0000);
    rd(OFF_STATUS, 16'h0000);
    $display("reset test done");
    give_verdict();
  end
endmodule
`default_nettype wire
